// File: logic/hcvr_responder.sv
// verb responder: decodes link commands, returns 32-bit responses
// assumes the link clock is free of mclk and frames are >= 48 bits

// Functional notes
// RQ1 - gpio capability bit 30 set
// RQ2 - gpio counts: 0 in, 0 out, 02h bidir
// RQ3 - knob capability: write flag, step count
// RQ4 - conn query returns four entries, low first
// RQ5 - adc nodes list their sum node
// RQ6 - digital input converter lists its pin
// RQ7 - mixer lists ports in three groups
// RQ8 - sum nodes list converter then mixer
// RQ9 - ports list four sums, then fout sum
// RQ10 - digital output pin lists its converter
// RQ11 - adc sums copy mixer, add mixer entry
// RQ12 - unsupported query node returns zero
// RQ13 - processing state reads zero, write ignored
// RQ14 - coefficient index read at vendor node
// RQ15 - coefficient index write stored, zero reply
// RQ16 - coefficient read returns selected value
// RQ17 - coefficient write accepted, zero reply
// RQ18 - format read for listed converters
// RQ19 - format type, base, multiple stored
// RQ20 - format size and channels stored
// RQ21 - divisor bits always read zero
// RQ22 - format write latched, zero reply
// RQ23 - unsupported verb returns all zeros
// RQ24 - index selects vendor coefficient register
// RQ25 - one response on the next frame
module hcvr_responder
	import hcvr_pkg::*;
#(
	parameter logic [3:0] CODEC_ADDR = 4'h0, // link address
	parameter int COEF_DEPTH = 16, // vendor coefficient count
	parameter logic KNOB_DELTA = 1'b1, // base volume writable
	parameter logic [6:0] KNOB_STEPS = 7'h3f // knob step count
) (
	// core clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// link side
	input wire logic link_bclk,
	input wire logic link_sync,
	input wire logic link_sdo,
	output logic link_sdi_o,
	output logic link_sdi_oe
);

	localparam int CW = (COEF_DEPTH > 1) ? $clog2(COEF_DEPTH) : 1;

	typedef enum logic [0:0] {
		hcvr_idle,
		hcvr_exec
	} hcvr_state_e;

	// ----------------------------------------
	// link domain
	// ----------------------------------------
	logic sync_prev_q; // sync seen last edge
	logic [5:0] bit_cnt_q; // command bit counter
	logic [CMD_BITS-1:0] cmd_shift_q; // incoming bits
	logic [CMD_BITS-1:0] cmd_word_q; // held for core
	logic cmd_tgl_q; // flips per command
	logic [RESP_BITS-1:0] resp_shift_q; // outgoing bits
	logic [5:0] resp_cnt_q; // response bits left
	logic rtgl_s1_q; // response toggle sync
	logic rtgl_s2_q;
	logic rtgl_seen_q; // last toggle sent
	logic frame_start; // rising sync
	logic [CMD_BITS-1:0] cmd_next; // completed word

	// core-domain signals read by the link
	logic resp_tgl_q;
	logic [31:0] resp_q;

	assign frame_start = link_sync & ~sync_prev_q;
	assign cmd_next = {cmd_shift_q[CMD_BITS-2:0], link_sdo};

	// sync edge detect
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			sync_prev_q <= 1'b0;
		end else begin
			sync_prev_q <= link_sync;
		end
	end

	// command bit counter, restarts at frame start
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_q <= CNT_DONE;
		end else if (frame_start) begin
			bit_cnt_q <= 6'h00;
		end else if (bit_cnt_q < 6'(CMD_BITS)) begin
			bit_cnt_q <= bit_cnt_q + 6'h01;
		end
	end

	// shift command in msb first; hand whole word to core
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			cmd_shift_q <= '0;
			cmd_word_q <= '0;
			cmd_tgl_q <= 1'b0;
		end else if (!frame_start && bit_cnt_q < 6'(CMD_BITS)) begin
			cmd_shift_q <= cmd_next;
			// last bit: keep only non-null words for this address
			if (bit_cnt_q == 6'(CMD_BITS - 1) && cmd_next != '0 &&
				cmd_next[31:28] == CODEC_ADDR) begin
				cmd_word_q <= cmd_next;
				cmd_tgl_q <= ~cmd_tgl_q; // [RQ25]
			end
		end
	end

	// response toggle synchroniser
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			rtgl_s1_q <= 1'b0;
			rtgl_s2_q <= 1'b0;
		end else begin
			rtgl_s1_q <= resp_tgl_q;
			rtgl_s2_q <= rtgl_s1_q;
		end
	end

	// send a pending response at the next frame start
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			resp_shift_q <= '0;
			resp_cnt_q <= 6'h00;
			rtgl_seen_q <= 1'b0;
		end else if (frame_start && (rtgl_s2_q != rtgl_seen_q)) begin
			// valid flag, unsolicited and reserved zero, data
			resp_shift_q <= {1'b1, 3'h0, resp_q}; // [RQ25]
			resp_cnt_q <= 6'(RESP_BITS);
			rtgl_seen_q <= rtgl_s2_q;
		end else if (resp_cnt_q != 6'h00) begin
			resp_shift_q <= {resp_shift_q[RESP_BITS-2:0], 1'b0};
			resp_cnt_q <= resp_cnt_q - 6'h01;
		end
	end

	// sdi pin: drive only while bits remain
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			link_sdi_o <= 1'b0;
			link_sdi_oe <= 1'b0;
		end else if (frame_start && (rtgl_s2_q != rtgl_seen_q)) begin
			link_sdi_o <= 1'b1; // valid flag first
			link_sdi_oe <= 1'b1;
		end else if (resp_cnt_q > 6'h01) begin
			link_sdi_o <= resp_shift_q[RESP_VALID_BIT-1];
			link_sdi_oe <= 1'b1;
		end else begin
			link_sdi_o <= 1'b0;
			link_sdi_oe <= 1'b0;
		end
	end

	// ----------------------------------------
	// core domain
	// ----------------------------------------
	logic ctgl_s1_q; // command toggle sync
	logic ctgl_s2_q;
	logic ctgl_s3_q; // edge reference
	logic [31:0] cmd_q; // command being decoded
	hcvr_state_e state_q;
	logic [15:0] idx_q; // vendor coefficient index
	logic [15:0] fmt_q [NUM_CONV]; // converter formats
	logic [15:0] coef_q [COEF_DEPTH]; // vendor coefficients
	logic [7:0] node_id; // addressed node
	logic [11:0] verb12; // long verb code
	logic [3:0] verb4; // short verb code
	logic [15:0] pay16; // short verb payload
	logic is_long; // long verb form
	logic exec; // decode cycle
	logic [NUM_CONV-1:0] conv_hit; // per-converter match
	logic [15:0] fmt_rd; // format of addressed node
	logic coef_ok; // index inside the bank
	logic [CW-1:0] coef_sel;
	logic [31:0] resp_d;

	assign node_id = cmd_q[27:20];
	assign verb12 = cmd_q[19:8];
	assign verb4 = cmd_q[19:16];
	assign pay16 = cmd_q[15:0];
	assign is_long = (verb4 == VERB_LONG_GET) || (verb4 == VERB_LONG_SET);
	assign exec = (state_q == hcvr_exec);
	assign coef_ok = (32'(idx_q) < COEF_DEPTH);
	assign coef_sel = idx_q[CW-1:0]; // [RQ24]

	// command toggle synchroniser
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctgl_s1_q <= 1'b0;
			ctgl_s2_q <= 1'b0;
			ctgl_s3_q <= 1'b0;
		end else begin
			ctgl_s1_q <= cmd_tgl_q;
			ctgl_s2_q <= ctgl_s1_q;
			ctgl_s3_q <= ctgl_s2_q;
		end
	end

	// capture held word, then one decode cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd_q <= '0;
			state_q <= hcvr_idle;
		end else begin
			case (state_q)
				hcvr_idle: begin
					if (ctgl_s2_q != ctgl_s3_q) begin
						cmd_q <= cmd_word_q;
						state_q <= hcvr_exec;
					end
				end
				hcvr_exec: begin
					state_q <= hcvr_idle;
				end
				default: begin
					state_q <= hcvr_idle;
				end
			endcase
		end
	end

	// connection list lookup by node and start index
	function automatic logic [31:0] conn_list(
		input logic [7:0] node,
		input logic [7:0] n
	);
		logic g0;
		logic g1;
		logic g2;
		logic [31:0] r;
		g0 = (n < GRP1_N);
		g1 = (n >= GRP1_N) && (n < GRP2_N);
		g2 = (n >= GRP2_N) && (n < GRP_END_N);
		r = '0; // [RQ12]
		case (node)
			NODE_LINE_ADC: if (g0) r = {24'h0, NODE_SUM_LINEADC}; // [RQ5]
			NODE_MIX_ADC: if (g0) r = {24'h0, NODE_SUM_MIXADC}; // [RQ5]
			NODE_DIG_IN: if (g0) r = {24'h0, NODE_DIG_IN_PIN}; // [RQ6]
			NODE_MIXER, NODE_SUM_MIXADC, NODE_SUM_LINEADC: begin
				if (g0) begin
					r = MIX_LIST0; // [RQ7]
				end else if (g1) begin
					r = MIX_LIST1; // [RQ7]
				end else if (g2) begin
					r = MIX_LIST2; // [RQ7]
					if (node != NODE_MIXER) begin
						r[23:16] = NODE_MIXER; // [RQ11]
					end
				end
			end
			NODE_SUM_FRONT: if (g0) r = {16'h0, NODE_MIXER, NODE_DAC_FRONT}; // [RQ8]
			NODE_SUM_SURR: if (g0) r = {16'h0, NODE_MIXER, NODE_DAC_SURR}; // [RQ8]
			NODE_SUM_CLFE: if (g0) r = {16'h0, NODE_MIXER, NODE_DAC_CLFE}; // [RQ8]
			NODE_SUM_SIDE: if (g0) r = {16'h0, NODE_MIXER, NODE_DAC_SIDE}; // [RQ8]
			NODE_SUM_FOUT: if (g0) r = {16'h0, NODE_MIXER, NODE_DAC_FOUT}; // [RQ8]
			NODE_DIG_OUT_PIN: if (g0) r = {24'h0, NODE_DIG_OUT_CONV}; // [RQ10]
			default: begin
				// port pins form a contiguous id range
				if (node >= NODE_PORT_FIRST && node <= NODE_PORT_LAST) begin
					if (g0) begin
						r = PORT_LIST0; // [RQ9]
					end else if (g1) begin
						r = {24'h0, NODE_SUM_FOUT}; // [RQ9]
					end
				end
			end
		endcase
		return r;
	endfunction

	// per-converter format storage
	generate
		for (genvar g = 0; g < NUM_CONV; g++) begin : g_conv
			assign conv_hit[g] = (node_id == CONV_NODES[g]);
			// divisor and bit 7 never stored
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					fmt_q[g] <= FMT_RESET;
				end else if (exec && !is_long && verb4 == VERB_SET_FMT &&
					conv_hit[g]) begin
					fmt_q[g] <= pay16 & FMT_WR_MASK; // [RQ19] [RQ20] [RQ21] [RQ22]
				end
			end
		end
	endgenerate

	// vendor coefficient bank at the vendor node
	generate
		for (genvar c = 0; c < COEF_DEPTH; c++) begin : g_coef
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					coef_q[c] <= COEF_RESET;
				end else if (exec && !is_long && verb4 == VERB_SET_COEF &&
					node_id == NODE_VENDOR && coef_ok && 32'(coef_sel) == c) begin
					coef_q[c] <= pay16; // [RQ17] [RQ24]
				end
			end
		end
	endgenerate

	// coefficient index register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			idx_q <= IDX_RESET;
		end else if (exec && !is_long && verb4 == VERB_SET_COEF_IDX &&
			node_id == NODE_VENDOR) begin
			idx_q <= pay16; // [RQ15]
		end
	end

	// format of the addressed converter, zero if none
	always_comb begin
		fmt_rd = '0;
		for (int i = 0; i < NUM_CONV; i++) begin
			if (conv_hit[i]) begin
				fmt_rd = fmt_q[i];
			end
		end
	end

	// response word; set verbs and unknown verbs answer zero
	always_comb begin
		resp_d = '0; // [RQ23] [RQ12]
		if (is_long) begin
			case (verb12)
				VERB_GET_PARAM: begin
					if (node_id == NODE_AFG && cmd_q[7:0] == PARAM_GPIO_CAP) begin
						resp_d[GPIO_UNSOL_BIT] = 1'b1; // [RQ1]
						resp_d[23:0] = {INPUT_PIN_COUNT, OUTPUT_PIN_COUNT,
							BIDIR_PIN_COUNT}; // [RQ2]
					end else if (node_id == NODE_KNOB &&
						cmd_q[7:0] == PARAM_KNOB_CAP) begin
						resp_d[7:0] = {KNOB_DELTA, KNOB_STEPS}; // [RQ3]
					end
				end
				VERB_GET_CONN: resp_d = conn_list(node_id, cmd_q[7:0]); // [RQ4]
				VERB_GET_PROC: resp_d = '0; // [RQ13]
				VERB_SET_PROC: resp_d = '0; // [RQ13]
				default: resp_d = '0;
			endcase
		end else begin
			case (verb4)
				VERB_GET_COEF_IDX: begin
					if (node_id == NODE_VENDOR) begin
						resp_d = {16'h0, idx_q}; // [RQ14]
					end
				end
				VERB_GET_COEF: begin
					if (node_id == NODE_VENDOR && coef_ok) begin
						resp_d = {16'h0, coef_q[coef_sel]}; // [RQ16] [RQ24]
					end
				end
				VERB_GET_FMT: resp_d = {16'h0, fmt_rd}; // [RQ18] [RQ21]
				default: resp_d = '0;
			endcase
		end
	end

	// register the answer and signal the link
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			resp_q <= '0;
			resp_tgl_q <= 1'b0;
		end else if (exec) begin
			resp_q <= resp_d;
			resp_tgl_q <= ~resp_tgl_q; // [RQ25]
		end
	end

endmodule

// File: logic/hcvr_pkg.sv
// constants for the link verb responder
// assumes a serial command/response link framed by a sync pulse

package hcvr_pkg;

	// ----------------------------------------
	// link framing
	// ----------------------------------------
	localparam int CMD_BITS = 32; // command bits per frame
	localparam int RESP_BITS = 36; // response bits per frame
	localparam int RESP_VALID_BIT = 35; // valid flag in response
	localparam logic [5:0] CNT_DONE = 6'h3f; // idle count value

	// ----------------------------------------
	// verb codes
	// ----------------------------------------
	localparam logic [11:0] VERB_GET_PARAM = 12'hf00;
	localparam logic [11:0] VERB_GET_CONN = 12'hf02;
	localparam logic [11:0] VERB_GET_PROC = 12'hf03;
	localparam logic [11:0] VERB_SET_PROC = 12'h703;
	localparam logic [3:0] VERB_LONG_GET = 4'hf;
	localparam logic [3:0] VERB_LONG_SET = 4'h7;
	localparam logic [3:0] VERB_GET_COEF_IDX = 4'hd;
	localparam logic [3:0] VERB_SET_COEF_IDX = 4'h5;
	localparam logic [3:0] VERB_GET_COEF = 4'hc;
	localparam logic [3:0] VERB_SET_COEF = 4'h4;
	localparam logic [3:0] VERB_GET_FMT = 4'ha;
	localparam logic [3:0] VERB_SET_FMT = 4'h2;
	localparam logic [7:0] PARAM_GPIO_CAP = 8'h11;
	localparam logic [7:0] PARAM_KNOB_CAP = 8'h13;

	// ----------------------------------------
	// node ids
	// ----------------------------------------
	localparam logic [7:0] NODE_AFG = 8'h01;
	localparam logic [7:0] NODE_DAC_FRONT = 8'h02;
	localparam logic [7:0] NODE_DAC_SURR = 8'h03;
	localparam logic [7:0] NODE_DAC_CLFE = 8'h04;
	localparam logic [7:0] NODE_DAC_SIDE = 8'h05;
	localparam logic [7:0] NODE_DIG_OUT_CONV = 8'h06;
	localparam logic [7:0] NODE_LINE_ADC = 8'h08;
	localparam logic [7:0] NODE_MIX_ADC = 8'h09;
	localparam logic [7:0] NODE_DIG_IN = 8'h0a;
	localparam logic [7:0] NODE_MIXER = 8'h0b;
	localparam logic [7:0] NODE_SUM_FRONT = 8'h0c;
	localparam logic [7:0] NODE_SUM_SURR = 8'h0d;
	localparam logic [7:0] NODE_SUM_CLFE = 8'h0e;
	localparam logic [7:0] NODE_SUM_SIDE = 8'h0f;
	localparam logic [7:0] NODE_DIG_OUT2 = 8'h10;
	localparam logic [7:0] NODE_PORT_FIRST = 8'h14;
	localparam logic [7:0] NODE_PORT_LAST = 8'h1b;
	localparam logic [7:0] NODE_DIG_OUT_PIN = 8'h1e;
	localparam logic [7:0] NODE_DIG_IN_PIN = 8'h1f;
	localparam logic [7:0] NODE_VENDOR = 8'h20;
	localparam logic [7:0] NODE_KNOB = 8'h21;
	localparam logic [7:0] NODE_SUM_MIXADC = 8'h22;
	localparam logic [7:0] NODE_SUM_LINEADC = 8'h23;
	localparam logic [7:0] NODE_DAC_FOUT = 8'h25;
	localparam logic [7:0] NODE_SUM_FOUT = 8'h26;

	// ----------------------------------------
	// connection lists and index groups
	// ----------------------------------------
	localparam logic [31:0] MIX_LIST0 = 32'h1b1a1918;
	localparam logic [31:0] MIX_LIST1 = 32'h15141d1c;
	localparam logic [31:0] MIX_LIST2 = 32'h00001716;
	localparam logic [31:0] PORT_LIST0 = 32'h0f0e0d0c;
	localparam logic [7:0] GRP1_N = 8'h04; // first n of 2nd group
	localparam logic [7:0] GRP2_N = 8'h08;
	localparam logic [7:0] GRP_END_N = 8'h0c;

	// ----------------------------------------
	// capability fields
	// ----------------------------------------
	localparam int GPIO_UNSOL_BIT = 30;
	localparam logic [7:0] INPUT_PIN_COUNT = 8'h00;
	localparam logic [7:0] OUTPUT_PIN_COUNT = 8'h00;
	localparam logic [7:0] BIDIR_PIN_COUNT = 8'h02;

	// ----------------------------------------
	// converters and storage
	// ----------------------------------------
	localparam int NUM_CONV = 10;
	localparam logic [7:0] CONV_NODES [NUM_CONV] = '{
		NODE_DAC_FRONT, NODE_DAC_SURR, NODE_DAC_CLFE, NODE_DAC_SIDE,
		NODE_DIG_OUT_CONV, NODE_DIG_OUT2, NODE_DAC_FOUT,
		NODE_LINE_ADC, NODE_MIX_ADC, NODE_DIG_IN};
	localparam logic [15:0] FMT_WR_MASK = 16'hf87f; // divisor, bit 7 zero
	localparam logic [15:0] FMT_RESET = 16'h0000;
	localparam logic [15:0] COEF_RESET = 16'h0000;
	localparam logic [15:0] IDX_RESET = 16'h0000;

endpackage

// File: dv/hcvr_props.sv
// link checker for the verb responder
// bound into hcvr_responder, sees only its ports
module hcvr_props
	import hcvr_pkg::*;
#(
	parameter logic [3:0] CODEC_ADDR = 4'h0
) (
	// clocks, reset
	input wire logic mclk,
	input wire logic resetn,
	// link
	input wire logic link_bclk,
	input wire logic link_sync,
	input wire logic link_sdo,
	input wire logic link_sdi_o,
	input wire logic link_sdi_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// tracking
	// ----
	logic sync_q, fs_q, pend_q, rp_q; // sync history, answer due
	logic [5:0] cnt_q, olen_q; // bit count, enable run
	logic [30:0] sh_q; // command bits so far
	logic [1:0] kind_q, rk_q; // 1 zero, 2 low half, 3 format
	wire logic fs = link_sync & ~sync_q; // frame start
	wire logic [31:0] word = {sh_q, link_sdo};
	wire logic [3:0] vb = word[19:16];
	wire logic [1:0] kind = (vb inside {4'h2, 4'h4, 4'h5} ||
		word[19:8] inside {12'h703, 12'hf03}) ? 2'h1 :
		(vb inside {4'hc, 4'hd}) ? 2'h2 : (vb == 4'ha) ? 2'h3 : 2'h0;
	// bit count from frame start, command shifter
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			sync_q <= 1'b0;
			fs_q <= 1'b0;
			cnt_q <= 6'h3f;
			sh_q <= '0;
		end else begin
			sync_q <= link_sync;
			fs_q <= fs;
			cnt_q <= fs ? 6'h01 : (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;
			sh_q <= word[30:0];
		end
	end
	// decode at the last command bit
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			pend_q <= 1'b0;
			kind_q <= 2'h0;
		end else if (cnt_q == 6'h20) begin
			pend_q <= (word != 32'h0) && (word[31:28] == CODEC_ADDR);
			kind_q <= kind;
		end
	end
	// answer shape kept for the frame, enable run length
	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			rp_q <= 1'b0;
			rk_q <= 2'h0;
			olen_q <= 6'h0;
		end else begin
			if (fs) begin
				rp_q <= pend_q;
				rk_q <= kind_q;
			end
			olen_q <= link_sdi_oe ? olen_q + 6'h01 : 6'h0;
		end
	end
	default clocking @(posedge link_bclk); endclocking
	default disable iff (!resetn);
	start_enable_a: assert property (fs_q |-> link_sdi_oe == pend_q)
		else $error("answer enable wrong at frame start");
	valid_flag_a: assert property (fs_q && link_sdi_oe |-> link_sdi_o)
		else $error("valid flag missing");
	unsol_zero_a: assert property (fs_q && link_sdi_oe |=> !link_sdi_o [*3])
		else $error("status bits not zero");
	enable_rise_a: assert property ($rose(link_sdi_oe) |-> fs_q)
		else $error("enable rose away from frame start");
	enable_len_a: assert property ($fell(link_sdi_oe) |-> olen_q == 6'h24)
		else $error("answer not 36 bits long");
	quiet_idle_a: assert property (!rp_q |-> !link_sdi_oe)
		else $error("answer without a command");
	set_zero_a: assert property (link_sdi_oe && rk_q == 2'h1 && olen_q > 6'h3
		|-> !link_sdi_o)
		else $error("set verb answer not zero");
	upper_zero_a: assert property (link_sdi_oe && rk_q[1]
		&& olen_q inside {[6'h4:6'h13]} |-> !link_sdi_o)
		else $error("upper answer half not zero");
	divisor_zero_a: assert property (link_sdi_oe && rk_q == 2'h3
		&& olen_q inside {[6'h19:6'h1c]} |-> !link_sdi_o)
		else $error("format divisor bits not zero");
endmodule

// File: dv/hcvr_host.sv
// host side of the link: bit clock, sync, commands out, answers in
// assumes a free running bit clock and a pulled-down answer line
module hcvr_host (
	// link
	output logic link_bclk,
	output logic link_sync,
	output logic link_sdo,
	input wire logic link_sdi_o,
	input wire logic link_sdi_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	wire logic sdi = link_sdi_oe ? link_sdi_o : 1'b0; // pull-down when released
	// bit clock, offset from the core clock
	initial begin
		link_bclk = 1'b0;
		link_sync = 1'b0;
		link_sdo = 1'b0;
		#3.7;
		forever #80 link_bclk = ~link_bclk;
	end
	// one frame: command msb first, previous answer captured
	task automatic frame(input logic [31:0] cmd, output logic [35:0] rsp);
		rsp = 36'h0;
		@(posedge link_bclk) #2 link_sync = 1'b1;
		@(posedge link_bclk) #2 link_sync = 1'b0;
		for (int i = 0; i < 48; i++) begin
			link_sdo = (i < 32) ? cmd[31 - i] : ~link_sdo;
			// answer bit launched at the last edge, settled by now
			if (i < 36)
				rsp = {rsp[34:0], sdi};
			@(posedge link_bclk);
			#2;
		end
	endtask
endmodule

// File: dv/test_hcvr_responder.sv
// self-checking bench for the verb responder
// assumes hcvr_host drives the link and hcvr_props is bound in
module test_hcvr_responder;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] ADDR = 4'h3; // codec address
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	wire logic link_bclk, link_sync, link_sdo, link_sdi_o, link_sdi_oe;
	int seed = 32'h565641cc;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [35:0] pend_exp = 36'h0; // answer due next frame
	logic [31:0] pend_cmd = 32'h0;
	logic [15:0] idx = 16'h0; // model state
	logic [15:0] coef [16] = '{default: 16'h0};
	logic [15:0] fmt [256] = '{default: 16'h0};
	logic [31:0] r;
	logic [7:0] nodes [15] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h26,
		8'h14, 8'h1b, 8'h1e, 8'h22, 8'h23, 8'h21};
	logic [7:0] convs [12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h10, 8'h25, 8'h08, 8'h09,
		8'h0a, 8'h0b, 8'h1e};
	logic [7:0] ns [6] = '{8'h00, 8'h03, 8'h04, 8'h08, 8'h0b, 8'h0c};
	always #10 mclk = ~mclk;
	hcvr_responder #(.CODEC_ADDR(ADDR), .COEF_DEPTH(16), .KNOB_DELTA(1'b1), .KNOB_STEPS(7'h25))
		hcvr_responder_inst (.mclk(mclk), .resetn(resetn), .link_bclk(link_bclk),
		.link_sync(link_sync), .link_sdo(link_sdo), .link_sdi_o(link_sdi_o),
		.link_sdi_oe(link_sdi_oe));
	hcvr_host hcvr_host_inst (.link_bclk(link_bclk), .link_sync(link_sync), .link_sdo(link_sdo),
		.link_sdi_o(link_sdi_o), .link_sdi_oe(link_sdi_oe));
	// connection list entries, four per answer, low entry first
	function automatic logic [31:0] conn(input logic [7:0] nd, input logic [7:0] n);
		logic [31:0] mix;
		mix = (n < 4) ? 32'h1b1a1918 : (n < 8) ? 32'h15141d1c : (n < 12) ? 32'h00001716 : 0;
		case (nd)
			8'h08: conn = (n < 4) ? 32'h23 : 0;
			8'h09: conn = (n < 4) ? 32'h22 : 0;
			8'h0a: conn = (n < 4) ? 32'h1f : 0;
			8'h1e: conn = (n < 4) ? 32'h06 : 0;
			8'h0b: conn = mix;
			8'h22, 8'h23: conn = mix | ((n > 7 && n < 12) ? 32'h000b0000 : 0);
			8'h0c, 8'h0d, 8'h0e, 8'h0f: conn = (n < 4) ? {24'h0b, nd - 8'h0a} : 0;
			8'h26: conn = (n < 4) ? 32'h0b25 : 0;
			default: conn = (nd < 8'h14 || nd > 8'h1b) ? 0 :
				(n < 4) ? 32'h0f0e0d0c : (n < 8) ? 32'h26 : 0;
		endcase
	endfunction
	// expected answer; updates model state as the device would
	function automatic logic [31:0] model(input logic [31:0] c);
		logic [7:0] nd;
		logic [3:0] v;
		nd = c[27:20];
		v = c[19:16];
		model = 32'h0;
		if (c[19:8] == 12'hf00 && c[7:0] == 8'h11 && nd == 8'h01)
			model = 32'h40000002;
		else if (c[19:8] == 12'hf00 && c[7:0] == 8'h13 && nd == 8'h21)
			model = 32'h000000a5;
		else if (c[19:8] == 12'hf02)
			model = conn(nd, c[7:0]);
		else if (v == 4'hf || v == 4'h7)
			model = 32'h0;
		else if (nd == 8'h20) begin
			if (v == 4'h5)
				idx = c[15:0];
			if (v == 4'h4 && idx < 16)
				coef[idx] = c[15:0];
			if (v == 4'hd)
				model = {16'h0, idx};
			if (v == 4'hc && idx < 16)
				model = {16'h0, coef[idx]};
		end else if (nd inside {[8'h02:8'h06], 8'h10, 8'h25, [8'h08:8'h0a]}) begin
			if (v == 4'h2)
				fmt[nd] = c[15:0] & 16'hf87f;
			if (v == 4'ha)
				model = {16'h0, fmt[nd]};
		end
	endfunction
	task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	// one frame out, the previous command's answer checked
	task automatic send(input logic [31:0] c);
		logic [35:0] got;
		hcvr_host_inst.frame(c, got);
		chk($sformatf("answer to %h", pend_cmd), pend_exp, got);
		pend_cmd = c;
		pend_exp = (c != 32'h0 && c[31:28] == ADDR) ? {4'h8, model(c)} : 36'h0;
	endtask
	task automatic close_out();
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		repeat (8) @(posedge link_bclk);
		#2 resetn = 1'b1;
		send({ADDR, 8'h01, 12'hf00, 8'h11});
		send({ADDR, 8'h21, 12'hf00, 8'h13});
		send({ADDR, 8'h21, 12'hf00, 8'h11});
		// every listing node, ports at the range ends only, across its group edges
		for (int k = 0; k < 48; k++)
			send({ADDR, nodes[k / 6], 12'hf02, ns[k % 6]});
		for (int k = 48; k < 90; k++)
			send({ADDR, nodes[k / 6], 12'hf02, ns[k % 6]});
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			send({ADDR, r[7:0], 12'hf03, r[15:8]});
			send({ADDR, r[23:16], 12'h703, r[31:24]});
		end
		// index selects the register; last pass is past the bank
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			send({ADDR, 8'h20, 4'h5, (k == 3) ? 16'h0010 : {12'h0, r[3:0]}});
			send({ADDR, 8'h20, 4'hc, 16'h0});
			send({ADDR, 8'h20, 4'h4, r[31:16]});
			send({ADDR, 8'h0b, 4'h5, r[15:0]});
			send({ADDR, 8'h0b, 4'hd, 16'h0});
			send({ADDR, 8'h0b, 4'hc, 16'h0});
			send({ADDR, 8'h20, 4'hd, 16'h0});
			send({ADDR, 8'h20, 4'hc, 16'h0});
		end
		send({ADDR, 8'h02, 4'h2, 16'hffff});
		foreach (convs[i]) begin
			r = $random(seed);
			send({ADDR, convs[i], 4'ha, 16'h0});
			send({ADDR, convs[i], 4'h2, r[15:0]});
		end
		foreach (convs[i])
			send({ADDR, convs[i], 4'ha, 16'h0});
		// refused: other address, null word
		send({~ADDR, 8'h01, 12'hf00, 8'h11});
		send(32'h0);
		repeat (8) begin
			r = $random(seed);
			send({ADDR, r[27:0]});
		end
		send(32'h0);
		close_out();
	end
endmodule
bind hcvr_responder hcvr_props #(.CODEC_ADDR(CODEC_ADDR)) hcvr_props_inst (.mclk(mclk),
	.resetn(resetn), .link_bclk(link_bclk), .link_sync(link_sync), .link_sdo(link_sdo),
	.link_sdi_o(link_sdi_o), .link_sdi_oe(link_sdi_oe));
